// file: rtl/fpc_flash_host.sv
// host controller that sequences commands into a parallel flash
module fpc_flash_host #(
  parameter int unsigned PROGRAM_TIMEOUT = fpc_pkg::PROGRAM_CYC,
  parameter int unsigned ERASE_TIMEOUT = fpc_pkg::ERASE_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [2:0] req_op,
  input wire logic [16:0] req_addr,
  input wire logic [7:0] req_data,
  input wire logic req_override,
  input wire logic boot_top,
  output logic resp_valid,
  output logic resp_error,
  output logic [7:0] resp_data,
  output logic [7:0] id_mfr,
  output logic [7:0] id_dev,
  output logic lock_state,
  output logic [16:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_reset_n,
  output logic hv_override
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ISSUE, ST_BUSWAIT, ST_POLL_ISSUE, ST_POLL_WAIT
  } fpc_state_t;

  fpc_state_t state;
  fpc_pkg::fpc_op_t op;
  fpc_pkg::fpc_op_t in_op;
  logic [16:0] addr;
  logic [7:0] data;
  logic [2:0] step;
  logic [2:0] len;
  logic [25:0] word;
  logic prev6;
  logic have_prev;
  logic [31:0] timer;
  logic bus_start;
  logic bus_write;
  logic [16:0] bus_addr;
  logic [7:0] bus_wdata;
  logic bus_done;
  logic [7:0] bus_rdata;
  logic refuse;
  logic needs_poll;
  logic poll_settled;

  // {is_read, address, data} for one step of the current command
  function automatic logic [25:0] step_word(input fpc_pkg::fpc_op_t o,
    input logic [2:0] idx, input logic [16:0] a, input logic [7:0] d,
    input logic top);
    logic [7:0] third;
    logic [7:0] sixth;
    logic [16:0] lock_addr;
    third = fpc_pkg::CMD_ERASE_SETUP;
    if (o == fpc_pkg::OP_PROGRAM) third = fpc_pkg::CMD_PROGRAM;
    if (o == fpc_pkg::OP_ID_READ) third = fpc_pkg::CMD_ID_ENTRY;
    if (o == fpc_pkg::OP_ID_EXIT) third = fpc_pkg::CMD_ID_EXIT;
    sixth = fpc_pkg::CMD_CHIP_ERASE;
    if (o == fpc_pkg::OP_SECTOR_ERASE) sixth = fpc_pkg::CMD_SECTOR_ERASE;
    if (o == fpc_pkg::OP_LOCKOUT) sixth = fpc_pkg::CMD_LOCKOUT;
    lock_addr = (top ? fpc_pkg::BOOT_TOP_LO : 17'h00000)
                | fpc_pkg::ID_LOCK_OFFSET;
    step_word = {1'b0, fpc_pkg::UNLOCK_ADDR_A, fpc_pkg::CMD_UNLOCK_A};
    if (o == fpc_pkg::OP_READ) begin
      step_word = {1'b1, a, 8'h00};
    end else if (o == fpc_pkg::OP_ID_EXIT_SHORT) begin
      step_word = {1'b0, a, fpc_pkg::CMD_ID_EXIT};
    end else begin
      case (idx)
        3'h0: step_word = {1'b0, fpc_pkg::UNLOCK_ADDR_A,
                           fpc_pkg::CMD_UNLOCK_A};
        3'h1: step_word = {1'b0, fpc_pkg::UNLOCK_ADDR_B,
                           fpc_pkg::CMD_UNLOCK_B};
        3'h2: step_word = {1'b0, fpc_pkg::UNLOCK_ADDR_A, third};
        3'h3: begin
          if (o == fpc_pkg::OP_PROGRAM) step_word = {1'b0, a, d};
          else if (o == fpc_pkg::OP_ID_READ)
            step_word = {1'b1, fpc_pkg::ID_MFR_ADDR, 8'h00};
          else step_word = {1'b0, fpc_pkg::UNLOCK_ADDR_A,
                            fpc_pkg::CMD_UNLOCK_A};
        end
        3'h4: begin
          if (o == fpc_pkg::OP_ID_READ)
            step_word = {1'b1, fpc_pkg::ID_DEV_ADDR, 8'h00};
          else step_word = {1'b0, fpc_pkg::UNLOCK_ADDR_B,
                            fpc_pkg::CMD_UNLOCK_B};
        end
        3'h5: begin
          if (o == fpc_pkg::OP_ID_READ) step_word = {1'b1, lock_addr, 8'h00};
          else if (o == fpc_pkg::OP_SECTOR_ERASE)
            step_word = {1'b0, a, sixth};
          else step_word = {1'b0, fpc_pkg::UNLOCK_ADDR_A, sixth};
        end
        default: step_word = {1'b0, a, fpc_pkg::CMD_ID_EXIT};
      endcase
    end
  endfunction : step_word

  assign in_op = fpc_pkg::fpc_op_t'(req_op);
  assign req_ready = (state == ST_IDLE);
  assign word = step_word(op, step, addr, data, boot_top);
  assign needs_poll = (op == fpc_pkg::OP_PROGRAM)
                      || (op == fpc_pkg::OP_CHIP_ERASE)
                      || (op == fpc_pkg::OP_SECTOR_ERASE)
                      || (op == fpc_pkg::OP_LOCKOUT);
  // while locked and without override, boot block programs and sector erases are refused up front rather than sent and ignored
  assign refuse = lock_state && !req_override
    && (in_op == fpc_pkg::OP_PROGRAM || in_op == fpc_pkg::OP_SECTOR_ERASE)
    && fpc_pkg::sector_of(req_addr, boot_top) == fpc_pkg::SEC_BOOT;
  // settled once bit 6 stops toggling and, for a program, bit 7 matches bit 7 of the written data
  assign poll_settled = have_prev && prev6 == bus_rdata[6]
    && (op != fpc_pkg::OP_PROGRAM || bus_rdata[7] == data[7]);

  always_comb begin
    unique case (op)
      fpc_pkg::OP_READ: len = fpc_pkg::LEN_SINGLE;
      fpc_pkg::OP_ID_EXIT_SHORT: len = fpc_pkg::LEN_SINGLE;
      fpc_pkg::OP_PROGRAM: len = fpc_pkg::LEN_PROGRAM;
      fpc_pkg::OP_ID_READ: len = fpc_pkg::LEN_ID_READ;
      fpc_pkg::OP_ID_EXIT: len = fpc_pkg::LEN_ID_EXIT;
      default: len = fpc_pkg::LEN_SIX;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flash_reset_n <= 1'b0;
    end else begin
      flash_reset_n <= 1'b1;
    end
  end

  // poll budget: running out means the part never reported completion
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      timer <= 32'h00000000;
    end else if (state == ST_BUSWAIT && bus_done && step + 3'h1 == len) begin
      timer <= (op == fpc_pkg::OP_PROGRAM) ? PROGRAM_TIMEOUT
                                           : ERASE_TIMEOUT;
    end else if (timer != 32'h00000000) begin
      timer <= timer - 32'h00000001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= ST_IDLE;
      op <= fpc_pkg::OP_READ;
      addr <= 17'h00000;
      data <= 8'h00;
      step <= 3'h0;
      prev6 <= 1'b0;
      have_prev <= 1'b0;
      bus_start <= 1'b0;
      bus_write <= 1'b0;
      bus_addr <= 17'h00000;
      bus_wdata <= 8'h00;
      resp_valid <= 1'b0;
      resp_error <= 1'b0;
      resp_data <= 8'h00;
      id_mfr <= 8'h00;
      id_dev <= 8'h00;
      lock_state <= 1'b0;
      hv_override <= 1'b0;
    end else begin
      bus_start <= 1'b0;
      resp_valid <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (req_valid && refuse) begin
            resp_valid <= 1'b1;
            resp_error <= 1'b1;
          end else if (req_valid) begin
            op <= in_op;
            addr <= req_addr;
            data <= req_data;
            step <= 3'h0;
            hv_override <= req_override;
            state <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          bus_start <= 1'b1;
          bus_write <= !word[25];
          bus_addr <= word[24:8];
          bus_wdata <= word[7:0];
          state <= ST_BUSWAIT;
        end
        ST_BUSWAIT: begin
          if (bus_done) begin
            if (op == fpc_pkg::OP_READ) resp_data <= bus_rdata;
            if (op == fpc_pkg::OP_ID_READ && step == 3'h3) id_mfr <= bus_rdata;
            if (op == fpc_pkg::OP_ID_READ && step == 3'h4) id_dev <= bus_rdata;
            if (op == fpc_pkg::OP_ID_READ && step == 3'h5)
              lock_state <= bus_rdata[0];
            if (step + 3'h1 != len) begin
              step <= step + 3'h1;
              state <= ST_ISSUE;
            end else if (needs_poll) begin
              // nothing else is sent until the poll settles or the timer runs out
              have_prev <= 1'b0;
              state <= ST_POLL_ISSUE;
            end else begin
              resp_valid <= 1'b1;
              resp_error <= 1'b0;
              hv_override <= 1'b0;
              state <= ST_IDLE;
            end
          end
        end
        ST_POLL_ISSUE: begin
          bus_start <= 1'b1;
          bus_write <= 1'b0;
          bus_addr <= addr;
          state <= ST_POLL_WAIT;
        end
        ST_POLL_WAIT: begin
          if (bus_done) begin
            prev6 <= bus_rdata[6];
            have_prev <= 1'b1;
            if (poll_settled || timer == 32'h00000000) begin
              resp_valid <= 1'b1;
              resp_data <= bus_rdata;
              resp_error <= !poll_settled
                || (op == fpc_pkg::OP_PROGRAM && bus_rdata != data);
              if (op == fpc_pkg::OP_LOCKOUT && poll_settled) lock_state <= 1'b1;
              hv_override <= 1'b0;
              state <= ST_IDLE;
            end else begin
              state <= ST_POLL_ISSUE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  fpc_bus_cycle u_bus (
    .clk_sys(clk_sys),
    .reset(reset),
    .start(bus_start),
    .write(bus_write),
    .addr_in(bus_addr),
    .wdata(bus_wdata),
    .done(bus_done),
    .rdata(bus_rdata),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n)
  );

  a_busy_not_ready: assert property (
    @(posedge clk_sys) disable iff (reset)
    state != ST_IDLE |-> !req_ready && !resp_valid || state == ST_IDLE)
    else $error("request accepted while busy");
  a_lock_refusal: assert property (
    @(posedge clk_sys) disable iff (reset)
    state == ST_IDLE && req_valid && refuse
      |=> resp_valid && resp_error && state == ST_IDLE)
    else $error("locked boot request not refused");
  a_hv_only_busy: assert property (
    @(posedge clk_sys) disable iff (reset)
    resp_valid |-> !hv_override)
    else $error("override still raised after completion");
  a_first_unlock: assert property (
    @(posedge clk_sys) disable iff (reset)
    bus_start && state == ST_BUSWAIT && $past(step) == 3'h0
      && op != fpc_pkg::OP_READ && op != fpc_pkg::OP_ID_EXIT_SHORT
      |-> bus_write && bus_addr == 17'h05555 && bus_wdata == 8'haa)
    else $error("first command write is not the unlock");
  a_poll_reads_only: assert property (
    @(posedge clk_sys) disable iff (reset)
    state == ST_POLL_WAIT |-> flash_we_n)
    else $error("write issued while waiting for completion");
  a_program_verify: assert property (
    @(posedge clk_sys) disable iff (reset)
    state == ST_POLL_WAIT && bus_done && op == fpc_pkg::OP_PROGRAM
      && bus_rdata != data |=> resp_error || state == ST_POLL_ISSUE)
    else $error("program mismatch not reported");
  c_program: cover property (@(posedge clk_sys) disable iff (reset)
    op == fpc_pkg::OP_PROGRAM && resp_valid && !resp_error);
  c_chip_erase: cover property (@(posedge clk_sys) disable iff (reset)
    op == fpc_pkg::OP_CHIP_ERASE && resp_valid);
  c_id_read: cover property (@(posedge clk_sys) disable iff (reset)
    op == fpc_pkg::OP_ID_READ && resp_valid);
endmodule : fpc_flash_host

// file: rtl/fpc_pkg.sv
// constants, types, sequence lengths and sector decode for the parallel flash host
package fpc_pkg;
  typedef enum logic [2:0] {
    OP_READ, OP_PROGRAM, OP_CHIP_ERASE, OP_SECTOR_ERASE,
    OP_LOCKOUT, OP_ID_READ, OP_ID_EXIT, OP_ID_EXIT_SHORT
  } fpc_op_t;

  typedef enum logic [2:0] {
    SEC_BOOT, SEC_PARAM_ONE, SEC_PARAM_TWO, SEC_MAIN_ONE, SEC_MAIN_TWO
  } fpc_sector_t;

  localparam logic [16:0] UNLOCK_ADDR_A = 17'h05555;
  localparam logic [16:0] UNLOCK_ADDR_B = 17'h02aaa;
  localparam logic [7:0] CMD_UNLOCK_A = 8'haa;
  localparam logic [7:0] CMD_UNLOCK_B = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_LOCKOUT = 8'h40;
  localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
  localparam logic [7:0] CMD_ID_EXIT = 8'hf0;

  localparam logic [16:0] BOOT_BOTTOM_HI = 17'h03fff;
  localparam logic [16:0] BOOT_TOP_LO = 17'h1c000;
  localparam logic [16:0] BOTTOM_PARAM_TWO_LO = 17'h06000;
  localparam logic [16:0] BOTTOM_MAIN_ONE_LO = 17'h08000;
  localparam logic [16:0] BOTTOM_MAIN_TWO_LO = 17'h10000;
  localparam logic [16:0] TOP_PARAM_ONE_LO = 17'h1a000;
  localparam logic [16:0] TOP_PARAM_TWO_LO = 17'h18000;
  localparam logic [16:0] TOP_MAIN_ONE_LO = 17'h10000;
  localparam logic [16:0] ID_MFR_ADDR = 17'h00000;
  localparam logic [16:0] ID_DEV_ADDR = 17'h00001;
  localparam logic [16:0] ID_LOCK_OFFSET = 17'h00002;

  localparam logic [2:0] LEN_SINGLE = 3'h1;
  localparam logic [2:0] LEN_PROGRAM = 3'h4;
  localparam logic [2:0] LEN_SIX = 3'h6;
  localparam logic [2:0] LEN_ID_READ = 3'h7;
  localparam logic [2:0] LEN_ID_EXIT = 3'h3;
  localparam int SYNC_STAGES = 3;

  localparam int CLK_NS = 8;
  localparam int T_SETUP_NS = 10;
  localparam int T_WE_LOW_NS = 40;
  localparam int T_HOLD_NS = 20;
  localparam int T_ACC_NS = 55;
  localparam int T_BYTE_PROGRAM_NS = 50000;
  localparam longint T_ERASE_MS = 10000;
  localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WE_LOW_CYC = 4'((T_WE_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HOLD_CYC = 4'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] READ_CYC =
    4'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
  localparam int unsigned PROGRAM_CYC =
    (T_BYTE_PROGRAM_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ERASE_CYC =
    32'((T_ERASE_MS * 64'd1000000 + CLK_NS - 1) / CLK_NS);

  function automatic fpc_sector_t sector_of(input logic [16:0] a,
                                            input logic top);
    if (top) begin
      if (a >= BOOT_TOP_LO) sector_of = SEC_BOOT;
      else if (a >= TOP_PARAM_ONE_LO) sector_of = SEC_PARAM_ONE;
      else if (a >= TOP_PARAM_TWO_LO) sector_of = SEC_PARAM_TWO;
      else if (a >= TOP_MAIN_ONE_LO) sector_of = SEC_MAIN_ONE;
      else sector_of = SEC_MAIN_TWO;
    end else begin
      if (a <= BOOT_BOTTOM_HI) sector_of = SEC_BOOT;
      else if (a < BOTTOM_PARAM_TWO_LO) sector_of = SEC_PARAM_ONE;
      else if (a < BOTTOM_MAIN_ONE_LO) sector_of = SEC_PARAM_TWO;
      else if (a < BOTTOM_MAIN_TWO_LO) sector_of = SEC_MAIN_ONE;
      else sector_of = SEC_MAIN_TWO;
    end
  endfunction : sector_of
endpackage : fpc_pkg

// file: rtl/fpc_bus_cycle.sv
// one timed asynchronous read or write cycle on the flash pins
module fpc_bus_cycle (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic start,
  input wire logic write,
  input wire logic [16:0] addr_in,
  input wire logic [7:0] wdata,
  output logic done,
  output logic [7:0] rdata,
  output logic [16:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n
);
  typedef enum logic [1:0] {
    BUS_IDLE, BUS_SETUP, BUS_STROBE, BUS_HOLD
  } fpc_bus_state_t;

  fpc_bus_state_t state;
  logic [3:0] cnt;
  logic is_write;
  logic [7:0] dq_s1;
  logic [7:0] dq_s2;
  logic [7:0] dq_s3;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
      dq_s3 <= 8'h00;
    end else begin
      dq_s1 <= flash_dq_in;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
    end
  end

  // address is set up before the strobe falls and data is held past its
  // rise, so both capture edges see stable values
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= BUS_IDLE;
      cnt <= 4'h0;
      is_write <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      flash_addr <= 17'h00000;
      flash_dq_out <= 8'h00;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
    end else begin
      done <= 1'b0;
      unique case (state)
        BUS_IDLE: begin
          if (start) begin
            flash_addr <= addr_in;
            flash_dq_out <= wdata;
            is_write <= write;
            flash_ce_n <= 1'b0;
            flash_oe_n <= write;
            flash_dq_oe <= write;
            cnt <= write ? fpc_pkg::SETUP_CYC - 4'h1
                         : fpc_pkg::READ_CYC - 4'h1;
            state <= write ? BUS_SETUP : BUS_STROBE;
          end
        end
        BUS_SETUP: begin
          if (cnt == 4'h0) begin
            flash_we_n <= 1'b0;
            cnt <= fpc_pkg::WE_LOW_CYC - 4'h1;
            state <= BUS_STROBE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        BUS_STROBE: begin
          if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
          end else if (is_write) begin
            flash_we_n <= 1'b1;
            cnt <= fpc_pkg::HOLD_CYC - 4'h1;
            state <= BUS_HOLD;
          end else if (dq_s2 == dq_s3) begin
            // a still-settling bus is simply waited out
            rdata <= dq_s3;
            flash_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            cnt <= fpc_pkg::HOLD_CYC - 4'h1;
            state <= BUS_HOLD;
          end
        end
        BUS_HOLD: begin
          if (cnt == 4'h0) begin
            flash_ce_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            done <= 1'b1;
            state <= BUS_IDLE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
      endcase
    end
  end

  a_write_gating: assert property (
    @(posedge clk_sys) disable iff (reset)
    !flash_we_n |-> flash_oe_n && !flash_ce_n)
    else $error("write strobe low while output gate low or chip unselected");
  a_we_pulse_width: assert property (
    @(posedge clk_sys) disable iff (reset)
    $fell(flash_we_n) |-> !flash_we_n[*5] ##1 flash_we_n)
    else $error("write strobe pulse not five cycles long");
  a_no_drive_read: assert property (
    @(posedge clk_sys) disable iff (reset)
    flash_dq_oe |-> flash_oe_n)
    else $error("data driven while output gate low");
  a_data_at_rise: assert property (
    @(posedge clk_sys) disable iff (reset)
    $rose(flash_we_n) |-> flash_dq_oe && !flash_ce_n
      && flash_dq_out == $past(flash_dq_out)
      && flash_addr == $past(flash_addr))
    else $error("data or address moved at write strobe rise");
  a_write_done: assert property (
    @(posedge clk_sys) disable iff (reset)
    state == BUS_IDLE && start && write |-> ##11 done)
    else $error("write cycle not finished in eleven cycles");
endmodule : fpc_bus_cycle

// file: dv/fpc_flash_model.sv
// behavioural parallel flash device facing the host controller
module fpc_flash_model #(
  parameter logic [7:0] MFR = 8'h3c, // arbitrary identity value
  parameter logic [7:0] DEV = 8'hc3 // arbitrary identity value
) (
  input wire logic [16:0] addr,
  input wire logic [7:0] din,
  output logic [7:0] dout,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic reset_n,
  input wire logic hv,
  input wire logic top
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:131071];
  logic [7:0] pd = 8'hff, last = 8'h00, rd, d;
  logic [16:0] la, a;
  logic [2:0] step = 0;
  logic busy = 0, tog = 0, lock = 0, idm = 0, arm = 0;
  realtime tf;
  wire drv = !ce_n && !oe_n && we_n && reset_n;
  function automatic logic boot(input logic [16:0] x);
    boot = top ? x >= 17'h1c000 : x <= 17'h03fff;
  endfunction : boot
  task automatic wipe(input int lo, input int hi);
    for (int i = lo; i <= hi; i++)
      if (!boot(17'(i)) || !lock || hv) mem[i] = 8'hff;
  endtask : wipe
  task automatic sector(input logic [16:0] x);
    if (top ? x < 17'h10000 : x >= 17'h10000)
      wipe(top ? 0 : 'h10000, top ? 'hffff : 'h1ffff);
    else if (top ? x < 17'h18000 : x >= 17'h08000)
      wipe(top ? 'h10000 : 'h4000, top ? 'h1bfff : 'hffff);
    else wipe(x & 17'h1e000, (x & 17'h1e000) + 'h1fff);
  endtask : sector
  initial for (int i = 0; i < 131072; i++) mem[i] = 8'hff;
  always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n) begin
    la = addr;
    tf = $realtime;
    arm = 1;
  end
  // busy work blocks this process, so writes during an operation are lost
  always @(posedge we_n or posedge ce_n) if (arm) begin
    arm = 0;
    d = din;
    a = la;
    if (!busy && oe_n && reset_n && $realtime - tf >= 15) begin
      if (d == 8'hf0) begin
        idm = 0;
        step = 0;
      end else case (step)
        0: step = (a == 17'h05555 && d == 8'haa) ? 1 : 0;
        1, 4: step = (a == 17'h02aaa && d == 8'h55) ? step + 1 : 0;
        2: begin
          step = 0;
          pd = 8'hff;
          if (a == 17'h05555 && d == 8'ha0) step = 3;
          if (a == 17'h05555 && d == 8'h80) step = 3'h4 - 1;
          if (a == 17'h05555 && d == 8'h90) idm = 1;
        end
        3: if (pd === 8'hfe) begin
          step = (a == 17'h05555 && d == 8'haa) ? 3'h4 : 3'h0;
          pd = 8'hff;
        end else begin
          step = 0;
          if (!boot(a) || !lock || hv) mem[a] = mem[a] & d;
          pd = d;
          busy = 1;
          #300 busy = 0;
        end
        default: begin
          step = 0;
          if (a == 17'h05555 && d == 8'h40) lock = 1;
          pd = 8'hff;
          if (a == 17'h05555 && d == 8'h10) begin
            busy = 1;
            wipe(0, 131071);
            #1000 busy = 0;
          end
          if (d == 8'h30 && !boot(a)) begin
            busy = 1;
            sector(a);
            #1000 busy = 0;
          end
        end
      endcase
      if (step == 3'h3 && d == 8'h80) pd = 8'hfe;
    end
  end
  always @(negedge reset_n) step = 0;
  always @(negedge oe_n) if (!ce_n && busy) tog = ~tog;
  assign rd = busy ? {~pd[7], tog, 6'h00} :
    idm ? (addr == 0 ? MFR : addr == 1 ? DEV : {7'h00, lock}) :
    mem[addr];
  always @(rd or drv) if (drv) last = rd;
  // a released bus never shows the last byte read
  assign dout = drv ? rd : ~last;
endmodule : fpc_flash_model

// file: dv/fpc_flash_host_tb.sv
// self-checking bench for the flash host controller
module fpc_flash_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MFR = 8'h3c;
  localparam logic [7:0] DEV = 8'hc3;
  logic clk_sys = 0, reset = 1, req_valid = 0, req_override = 0;
  logic boot_top = 0;
  logic [2:0] req_op = 0;
  logic [16:0] req_addr = 0, flash_addr;
  logic [7:0] req_data = 0, resp_data, id_mfr, id_dev, flash_dq_out, dev_dq;
  logic req_ready, resp_valid, resp_error, flash_dq_oe, lock_state;
  logic flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n, hv_override;
  wire [7:0] flash_dq_in = flash_dq_oe ? flash_dq_out : dev_dq;
  int miscompares = 0, tests_run = 0, cycles = 0;
  always #4 clk_sys = ~clk_sys;
  fpc_flash_host #(.PROGRAM_TIMEOUT(200), .ERASE_TIMEOUT(2000)) i_dut (
    .clk_sys(clk_sys), .reset(reset), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
    .req_data(req_data), .req_override(req_override), .boot_top(boot_top),
    .resp_valid(resp_valid), .resp_error(resp_error),
    .resp_data(resp_data), .id_mfr(id_mfr), .id_dev(id_dev),
    .lock_state(lock_state), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_reset_n(flash_reset_n), .hv_override(hv_override));
  fpc_flash_model #(.MFR(MFR), .DEV(DEV)) i_dev (
    .addr(flash_addr), .din(flash_dq_out), .dout(dev_dq),
    .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
    .reset_n(flash_reset_n), .hv(hv_override), .top(boot_top));
  task automatic final_report;
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // one request, held until taken, then wait for its response
  task automatic run(input logic [2:0] op, input logic [16:0] a,
                     input logic [7:0] d, input logic ovr);
    @(posedge clk_sys);
    req_valid <= 1;
    req_op <= op;
    req_addr <= a;
    req_data <= d;
    req_override <= ovr;
    do @(posedge clk_sys); while (req_ready !== 1'b1);
    req_valid <= 0;
    do @(posedge clk_sys); while (resp_valid !== 1'b1);
  endtask : run
  task automatic t_program;
    run(fpc_pkg::OP_PROGRAM, 17'h04010, 8'h5a, 0);
    check("program error", 8'h00, resp_error);
    run(fpc_pkg::OP_READ, 17'h04010, 8'h00, 0);
    check("program read", 8'h5a, resp_data);
    run(fpc_pkg::OP_PROGRAM, 17'h04010, 8'ha5, 0);
    check("reprogram error", 8'h01, resp_error);
    check("reprogram cell", 8'h00, i_dev.mem[17'h04010]);
  endtask : t_program
  task automatic t_lock;
    run(fpc_pkg::OP_LOCKOUT, 17'h05555, 8'h00, 0);
    run(fpc_pkg::OP_ID_READ, 17'h00000, 8'h00, 0);
    check("lock state", 8'h01, lock_state);
    check("id maker", MFR, id_mfr);
    check("id device", DEV, id_dev);
    run(fpc_pkg::OP_PROGRAM, 17'h00100, 8'h12, 0);
    check("boot refused", 8'h01, resp_error);
    check("boot kept", 8'hff, i_dev.mem[17'h00100]);
    run(fpc_pkg::OP_SECTOR_ERASE, 17'h00000, 8'h00, 0);
    check("boot erase", 8'h01, resp_error);
    run(fpc_pkg::OP_PROGRAM, 17'h00100, 8'h12, 1);
    check("override", 8'h12, i_dev.mem[17'h00100]);
  endtask : t_lock
  task automatic t_erase;
    run(fpc_pkg::OP_PROGRAM, 17'h10020, 8'h00, 0);
    run(fpc_pkg::OP_SECTOR_ERASE, 17'h08000, 8'h00, 0);
    check("param erased", 8'hff, i_dev.mem[17'h04010]);
    check("main two kept", 8'h00, i_dev.mem[17'h10020]);
    run(fpc_pkg::OP_CHIP_ERASE, 17'h10020, 8'h00, 0);
    check("chip erased", 8'hff, i_dev.mem[17'h10020]);
    check("boot survives", 8'h12, i_dev.mem[17'h00100]);
    run(fpc_pkg::OP_ID_EXIT_SHORT, 17'h00000, 8'h00, 0);
    run(fpc_pkg::OP_READ, 17'h00100, 8'h00, 0);
    check("read mode", 8'h12, resp_data);
  endtask : t_erase
  task automatic t_top;
    @(posedge clk_sys);
    boot_top <= 1;
    run(fpc_pkg::OP_PROGRAM, 17'h1c100, 8'h34, 0);
    check("top boot refused", 8'h01, resp_error);
    check("top boot kept", 8'hff, i_dev.mem[17'h1c100]);
    run(fpc_pkg::OP_PROGRAM, 17'h00100, 8'h02, 0);
    check("top low open", 8'h00, resp_error);
    check("top low cell", 8'h02, i_dev.mem[17'h00100]);
    run(fpc_pkg::OP_ID_READ, 17'h00000, 8'h00, 0);
    check("top lock bit", 8'h01, lock_state);
  endtask : t_top
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 0;
    t_program();
    t_lock();
    t_erase();
    t_top();
    final_report();
  end
endmodule : fpc_flash_host_tb
